// ===== rtl/tfm_map.svh
/*
 Constants of the telemetry frame multiplexer: the frame item widths,
 the sync pattern, the filler byte and the time-code field widths.
 Assumes it is included by the package and the design files by bare name.
*/
// Operation
// - Each frame opens with the fixed 32-bit sync word FE6B2840.
// - Time-code words follow the sync word, or another time-code channel, directly.
// - A time-code channel is 64 bits: two 24-bit words, then one 16-bit word.
// - Encoded time is the time latched at start of that frame.
// - Time word one: day 23..14, zero at 13, hour 12..7, minute 6..0.
// - Time word two: zero at 23, seconds 22..16, zeros 13..12, milliseconds 11..0.
// - Word two bit 15 flags a time-code decoding error.
// - Word two bit 14 flags that no time-code input is detected.
// - Time word three: zeros at 15..14, hundreds of nanoseconds at 13..0.
// - Serial data goes in 16-bit words, about two percent over-allocated.
// - Two identical count words of valid bits lead each serial channel; rest filler. Here unused low bits of a last partial word are zero, not filler.
// - First serial bit after frame start lands in MSB of third word.
// - Analog samples are 8- or 12-bit offset binary, zero most negative.
// - First analog sample at frame start, rest evenly spaced, no count words.
// - Voice channels are analog channels with 8-bit samples.
// - Parallel channels get about two percent more words than needed.
// - Two identical 16-bit counts of used 8-bit words lead; rest is filler.
// - First parallel data word is first input word after frame start.
// - Recording starts with a setup block; later frames follow its layout.
// - Frames go out MSB first and are a multiple of eight bits long.
// - Twelve-bit words occur an even number of times per frame.
// - Without analog padding, FF filler bytes fill to the channel start point.
// - Serial then parallel channels, slowest first, ties by hardware sequence.
`ifndef TFM_MAP_SVH
`define TFM_MAP_SVH
`define TFM_SYNC_WORD 32'hfe6b2840
`define TFM_SYNC_W 6'h20
`define TFM_TCA_W 6'h18
`define TFM_TCB_W 6'h18
`define TFM_TCC_W 6'h10
`define TFM_FILL_W 6'h08
`define TFM_CNT_W 6'h10
`define TFM_SER_W 6'h10
`define TFM_PAR_W 6'h08
`define TFM_SETUP_W 6'h10
`define TFM_FILL_BYTE 8'hff
`define TFM_SHIFT_W 32
`define TFM_PCT_PAD 2
`define TFM_PCT_DIV 100
`define TFM_SEG_SCAN 4
`endif

// ===== rtl/tfm_pkg.sv
/*
 Types of the telemetry frame multiplexer: frame segments, the time
 value carried into the time-code words, and the outgoing stream.
 Assumes the constant header sits beside it.
*/
`include "tfm_map.svh"
package tfm_pkg;
   // Frame items in the order they are sent
   typedef enum logic [3:0] {
      TFM_SEG_BOOT,
      TFM_SEG_SETUP,
      TFM_SEG_SYNC,
      TFM_SEG_TCA,
      TFM_SEG_TCB,
      TFM_SEG_TCC,
      TFM_SEG_FILL,
      TFM_SEG_SCNT,
      TFM_SEG_SDAT,
      TFM_SEG_PCNT,
      TFM_SEG_PDAT,
      TFM_SEG_ANA
   } tfm_seg_t;

   // Decoded time from the time-code reader
   typedef struct packed {
      logic [9:0] day;
      logic [5:0] hour;
      logic [6:0] minute;
      logic [6:0] second;
      logic [11:0] millisecond_field;
      logic [13:0] sub_ms_hundred_ns;
      logic time_sync_error_flag;
      logic time_input_absent_flag;
   } tfm_time_t;

   // Serial stream toward the recorder
   typedef struct packed {
      logic bit_out;
      logic bit_valid;
      logic frame_start;
   } tfm_stream_t;
endpackage : tfm_pkg

// ===== rtl/tfm_chan_acc.sv
/*
 Double-banked capture for one input channel: units of IN_W bits are
 packed MSB first into WORD_W-bit words during one frame, then read out
 while the next frame fills the other bank.
 Assumes i_swap pulses for one cycle at each frame start.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tfm_map.svh"
module tfm_chan_acc
   import tfm_pkg::*;
#(
   parameter int IN_W = 1,
   parameter int WORD_W = 16,
   parameter int NWORDS = 4,
   parameter logic [WORD_W-1:0] FILL = '1
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_swap,
   input wire logic i_valid,
   input wire logic [IN_W-1:0] i_data,
   input wire logic [15:0] i_rd_idx,
   output logic [WORD_W-1:0] o_rd_word,
   output logic [15:0] o_count
);
   localparam int UPW = WORD_W / IN_W;
   localparam logic [15:0] CAP = 16'(NWORDS * UPW);

   typedef struct packed {
      logic bank;
      logic [15:0] wr_cnt;
      logic [WORD_W-1:0] part;
      logic [1:0][NWORDS-1:0][WORD_W-1:0] mem;
      logic [15:0] cnt_out;
   } tfm_acc_t;

   tfm_acc_t q, d;

   // Frame swap first, so a unit arriving with the swap opens the new frame
   always_comb begin
      logic [WORD_W+IN_W-1:0] cat;
      logic [15:0] fill_units;
      cat = '0;
      fill_units = '0;
      d = q;
      if (i_swap) begin
         fill_units = 16'(q.wr_cnt % 16'(UPW));
         if (fill_units != '0) begin // Partial word left-aligned, low bits zero
            d.mem[q.bank][q.wr_cnt / 16'(UPW)] =
               WORD_W'(q.part << (IN_W * (UPW - int'(fill_units))));
         end
         d.cnt_out = q.wr_cnt; // Units that hold real data
         d.bank = ~q.bank;
         d.wr_cnt = '0;
         d.part = '0;
         for (int i = 0; i < NWORDS; i++) begin
            d.mem[~q.bank][i] = FILL;
         end
      end
      // Over-capacity units are dropped; allocation margin keeps this rare
      if (i_valid && d.wr_cnt < CAP) begin // First unit lands in word MSB
         cat = {d.part, i_data};
         d.part = cat[WORD_W-1:0];
         if (((d.wr_cnt + 16'h0001) % 16'(UPW)) == '0) begin
            d.mem[d.bank][d.wr_cnt / 16'(UPW)] = cat[WORD_W-1:0];
         end
         d.wr_cnt = d.wr_cnt + 16'h0001;
      end
   end

   // State register
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q <= '0;
         q.mem <= {2 * NWORDS{FILL}}; // Banks start as filler so the first frame reads clean
      end else begin
         q <= d;
      end
   end

   // Readout comes from the bank filled during the previous frame
   assign o_rd_word = (i_rd_idx < 16'(NWORDS)) ? q.mem[~q.bank][i_rd_idx] : FILL;
   assign o_count = q.cnt_out;
endmodule : tfm_chan_acc
`default_nettype wire

// ===== rtl/tfm_framer.sv
/*
 Composite frame builder: setup block once after reset, then endless
 frames of sync, one time-code channel, FF filler, a serial channel,
 a parallel channel and an analog channel, sent one bit per clock.
 Assumes inputs synchronous to i_clk and a converter giving offset
 binary samples on i_ana_sample whenever it is strobed.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tfm_map.svh"
module tfm_framer
   import tfm_pkg::*;
#(
   parameter bit TC_EN = 1'b1,
   parameter int FILL_BYTES = 7,
   parameter int SER_NOM_WORDS = 8,
   parameter int PAR_NOM_WORDS = 8,
   parameter int ANA_W = 12,
   parameter int ANA_NOM = 4,
   parameter int SETUP_N = 2,
   parameter logic [SETUP_N-1:0][15:0] SETUP_IMG = '0
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire tfm_time_t i_time,
   input wire logic i_ser_bit,
   input wire logic i_ser_valid,
   input wire logic [7:0] i_par_word,
   input wire logic i_par_valid,
   input wire logic [ANA_W-1:0] i_ana_sample,
   output tfm_stream_t o_tx,
   output logic o_ana_strobe
);
   // Allocation rounds the two percent margin up
   localparam int SER_N = SER_NOM_WORDS +
      (SER_NOM_WORDS * `TFM_PCT_PAD + `TFM_PCT_DIV - 1) / `TFM_PCT_DIV;
   localparam int PAR_N = PAR_NOM_WORDS +
      (PAR_NOM_WORDS * `TFM_PCT_PAD + `TFM_PCT_DIV - 1) / `TFM_PCT_DIV;
   // Twelve-bit samples rounded to an even count keep the frame byte aligned
   localparam int ANA_N = (ANA_W == 12 && (ANA_NOM % 2) != 0) ? ANA_NOM + 1 : ANA_NOM;
   localparam int FRAME_BITS = 32 + (TC_EN ? 64 : 0) + 8 * FILL_BYTES +
      16 * (2 + SER_N) + 16 * 2 + 8 * PAR_N + ANA_W * ANA_N;
   localparam int PACE = FRAME_BITS / ANA_N;
   localparam logic [15:0] PACE_LAST = 16'(PACE - 1);
   localparam logic [15:0] FRAME_LAST = 16'(FRAME_BITS - 1);

   typedef struct packed {
      tfm_seg_t seg;
      logic [15:0] idx;
      logic [5:0] left;
      logic [`TFM_SHIFT_W-1:0] sh;
      tfm_time_t tout;
      logic [15:0] pace_cnt;
      logic [15:0] ana_taken;
      tfm_stream_t tx;
      logic ana_strobe;
   } tfm_frm_t;

   tfm_frm_t q, d;
   logic [1:0] rst_pipe_q;
   logic rst_b;
   logic swap;
   logic ana_take;
   logic [15:0] rd_idx;
   logic [15:0] ser_cnt, par_cnt;
   logic [15:0] ser_word;
   logic [7:0] par_word;
   logic [ANA_W-1:0] ana_word;

   // Reset asserts asynchronously but releases through two flops
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_pipe_q <= 2'h0;
      end else begin
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
      end
   end
   assign rst_b = rst_pipe_q[1];

   // Words in each frame item
   function automatic logic [15:0] seg_len(input tfm_seg_t s);
      case (s)
         TFM_SEG_BOOT: seg_len = 16'h0001;
         TFM_SEG_SETUP: seg_len = 16'(SETUP_N);
         TFM_SEG_SYNC: seg_len = 16'h0001;
         TFM_SEG_TCA, TFM_SEG_TCB, TFM_SEG_TCC: seg_len = TC_EN ? 16'h0001 : 16'h0000;
         TFM_SEG_FILL: seg_len = 16'(FILL_BYTES);
         TFM_SEG_SCNT, TFM_SEG_PCNT: seg_len = 16'h0002;
         TFM_SEG_SDAT: seg_len = 16'(SER_N);
         TFM_SEG_PDAT: seg_len = 16'(PAR_N);
         TFM_SEG_ANA: seg_len = 16'(ANA_N);
         default: seg_len = 16'h0001;
      endcase
   endfunction : seg_len

   // Bits per word of each frame item
   function automatic logic [5:0] seg_w(input tfm_seg_t s);
      case (s)
         TFM_SEG_SETUP: seg_w = `TFM_SETUP_W;
         TFM_SEG_SYNC: seg_w = `TFM_SYNC_W;
         TFM_SEG_TCA: seg_w = `TFM_TCA_W; // Two 24-bit words then a 16-bit one
         TFM_SEG_TCB: seg_w = `TFM_TCB_W;
         TFM_SEG_TCC: seg_w = `TFM_TCC_W;
         TFM_SEG_FILL: seg_w = `TFM_FILL_W;
         TFM_SEG_SCNT, TFM_SEG_PCNT: seg_w = `TFM_CNT_W;
         TFM_SEG_SDAT: seg_w = `TFM_SER_W;
         TFM_SEG_PDAT: seg_w = `TFM_PAR_W;
         TFM_SEG_ANA: seg_w = 6'(ANA_W);
         default: seg_w = 6'h01;
      endcase
   endfunction : seg_w

   // Fixed item order; empty items are skipped
   function automatic tfm_seg_t seg_next(input tfm_seg_t s);
      case (s)
         TFM_SEG_BOOT: seg_next = TFM_SEG_SETUP; // Setup block precedes the first frame
         TFM_SEG_SETUP: seg_next = TFM_SEG_SYNC;
         TFM_SEG_SYNC: seg_next = TFM_SEG_TCA;
         TFM_SEG_TCA: seg_next = TFM_SEG_TCB;
         TFM_SEG_TCB: seg_next = TFM_SEG_TCC;
         TFM_SEG_TCC: seg_next = TFM_SEG_FILL;
         TFM_SEG_FILL: seg_next = TFM_SEG_SCNT;
         TFM_SEG_SCNT: seg_next = TFM_SEG_SDAT;
         TFM_SEG_SDAT: seg_next = TFM_SEG_PCNT;
         TFM_SEG_PCNT: seg_next = TFM_SEG_PDAT;
         TFM_SEG_PDAT: seg_next = TFM_SEG_ANA;
         TFM_SEG_ANA: seg_next = TFM_SEG_SYNC;
         default: seg_next = TFM_SEG_SYNC;
      endcase
   endfunction : seg_next

   // Serial channel capture, one bit per unit into 16-bit words
   tfm_chan_acc #(.IN_W(1), .WORD_W(16), .NWORDS(SER_N), .FILL(16'hffff)) u_ser (
      .i_clk(i_clk),
      .i_rst_b(rst_b),
      .i_swap(swap),
      .i_valid(i_ser_valid),
      .i_data(i_ser_bit),
      .i_rd_idx(rd_idx),
      .o_rd_word(ser_word),
      .o_count(ser_cnt)
   );

   // Parallel channel capture, one 8-bit word per unit
   tfm_chan_acc #(.IN_W(8), .WORD_W(8), .NWORDS(PAR_N), .FILL(`TFM_FILL_BYTE)) u_par (
      .i_clk(i_clk),
      .i_rst_b(rst_b),
      .i_swap(swap),
      .i_valid(i_par_valid),
      .i_data(i_par_word),
      .i_rd_idx(rd_idx),
      .o_rd_word(par_word),
      .o_count(par_cnt)
   );

   // Analog samples pass through unchanged as offset binary
   tfm_chan_acc #(.IN_W(ANA_W), .WORD_W(ANA_W), .NWORDS(ANA_N), .FILL('0)) u_ana (
      .i_clk(i_clk),
      .i_rst_b(rst_b),
      .i_swap(swap),
      .i_valid(ana_take),
      .i_data(i_ana_sample),
      .i_rd_idx(rd_idx),
      .o_rd_word(ana_word),
      .o_count()
   );

   // Bit sequencer, frame start events and the analog pacer
   always_comb begin
      tfm_seg_t s;
      logic [15:0] ni;
      logic [`TFM_SHIFT_W-1:0] w;
      s = q.seg;
      ni = '0;
      w = '0;
      d = q;
      swap = 1'b0;
      rd_idx = q.idx;
      d.tx.frame_start = 1'b0;
      if (q.left == 6'h01) begin
         ni = q.idx + 16'h0001;
         if (ni >= seg_len(q.seg)) begin
            ni = '0;
            s = seg_next(q.seg);
            for (int k = 0; k < `TFM_SEG_SCAN; k++) begin
               if (seg_len(s) == '0) begin
                  s = seg_next(s);
               end
            end
         end
         rd_idx = ni;
         if (s == TFM_SEG_SYNC) begin // Time caught at the opening of each frame
            swap = 1'b1;
            d.tx.frame_start = 1'b1;
            d.tout = i_time; // Same frame's start time, no one-frame lag
         end
         case (s)
            TFM_SEG_SETUP: w = 32'(SETUP_IMG[ni]);
            TFM_SEG_SYNC: w = `TFM_SYNC_WORD;
            TFM_SEG_TCA: w = 32'({d.tout.day, 1'b0, d.tout.hour, d.tout.minute});
            TFM_SEG_TCB: w = 32'({1'b0, d.tout.second, d.tout.time_sync_error_flag,
               d.tout.time_input_absent_flag, 2'h0, d.tout.millisecond_field});
            TFM_SEG_TCC: w = 32'({2'h0, d.tout.sub_ms_hundred_ns});
            TFM_SEG_FILL: w = 32'(`TFM_FILL_BYTE);
            TFM_SEG_SCNT: w = 32'(ser_cnt); // Same count sent twice
            TFM_SEG_SDAT: w = 32'(ser_word);
            TFM_SEG_PCNT: w = 32'(par_cnt);
            TFM_SEG_PDAT: w = 32'(par_word);
            TFM_SEG_ANA: w = 32'(ana_word);
            default: w = '0;
         endcase
         d.seg = s;
         d.idx = ni;
         d.left = seg_w(s);
         d.sh = w << (6'(`TFM_SHIFT_W) - seg_w(s)); // Left-aligned so MSB leaves first
      end else begin
         d.sh = q.sh << 1;
         d.left = q.left - 6'h01;
      end
      d.tx.bit_out = d.sh[`TFM_SHIFT_W-1];
      d.tx.bit_valid = (d.seg != TFM_SEG_BOOT);
      // Pacer restarts at frame start so the first sample lands on it
      ana_take = 1'b0;
      if (swap) begin
         ana_take = 1'b1;
         d.pace_cnt = '0;
         d.ana_taken = 16'h0001;
      end else if (q.pace_cnt == PACE_LAST) begin
         d.pace_cnt = '0;
         if (q.ana_taken < 16'(ANA_N)) begin
            ana_take = 1'b1;
            d.ana_taken = q.ana_taken + 16'h0001;
         end
      end else begin
         d.pace_cnt = q.pace_cnt + 16'h0001;
      end
      d.ana_strobe = ana_take;
   end

   // State register; reset parks in the boot slot so the setup block goes first
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         q.seg <= TFM_SEG_BOOT;
         q.left <= 6'h01;
      end else begin
         q <= d;
      end
   end

   assign o_tx = q.tx;
   assign o_ana_strobe = q.ana_strobe;

   // Checks on the built stream
   logic [15:0] fbits_q;
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         fbits_q <= '0;
      end else if (q.tx.frame_start) begin
         fbits_q <= 16'h0001;
      end else if (fbits_q != '0) begin // Idle until the first sync, so setup is not measured
         fbits_q <= fbits_q + 16'h0001;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_b);

   property p_sync_word;
      q.tx.frame_start |-> q.seg == TFM_SEG_SYNC && q.sh == `TFM_SYNC_WORD;
   endproperty
   a_sync_word: assert property (p_sync_word) else $error("sync word wrong");

   property p_tc_follows;
      (q.seg == TFM_SEG_SYNC && TC_EN) |-> ##[1:32] q.seg == TFM_SEG_TCA;
   endproperty
   a_tc_follows: assert property (p_tc_follows) else $error("time code not after sync");

   property p_tc_len;
      (q.seg == TFM_SEG_TCA && q.left == 6'h18) |-> ##24 q.seg == TFM_SEG_TCB ##24 q.seg == TFM_SEG_TCC
         ##16 q.seg != TFM_SEG_TCC;
   endproperty
   a_tc_len: assert property (p_tc_len) else $error("time code lengths wrong");

   property p_tc_time;
      (q.seg == TFM_SEG_TCA && q.left == 6'h18) |-> q.sh[31:22] == q.tout.day && !q.sh[21];
   endproperty
   a_tc_time: assert property (p_tc_time) else $error("time word one wrong");

   property p_tcb_bits;
      (q.seg == TFM_SEG_TCB && q.left == 6'h18) |-> !q.sh[31] && q.sh[23] == q.tout.time_sync_error_flag
         && q.sh[22] == q.tout.time_input_absent_flag && q.sh[21:20] == 2'h0;
   endproperty
   a_tcb_bits: assert property (p_tcb_bits) else $error("time word two flags wrong");

   property p_tcc_bits;
      (q.seg == TFM_SEG_TCC && q.left == 6'h10) |-> q.sh[31:30] == 2'h0;
   endproperty
   a_tcc_bits: assert property (p_tcc_bits) else $error("time word three wrong");

   property p_ser_count;
      (q.seg == TFM_SEG_SCNT && q.idx == 16'h0001 && q.left == 6'h10) |-> q.sh[31:16] == ser_cnt
         && $past(q.sh[31:16], 16) == ser_cnt;
   endproperty
   a_ser_count: assert property (p_ser_count) else $error("serial counts differ");

   property p_par_count;
      (q.seg == TFM_SEG_PCNT && q.idx == 16'h0001 && q.left == 6'h10) |-> q.sh[31:16] == par_cnt;
   endproperty
   a_par_count: assert property (p_par_count) else $error("parallel count wrong");

   property p_frame_len;
      (q.tx.frame_start && fbits_q > 16'h0001) |-> $past(fbits_q) == FRAME_LAST
         && (FRAME_BITS % 8) == 0;
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

   property p_ana_start;
      q.tx.frame_start |-> q.ana_strobe;
   endproperty
   a_ana_start: assert property (p_ana_start) else $error("no sample at frame start");
endmodule : tfm_framer
`default_nettype wire

// ===== sim/tfm_recorder_model.sv
/*
 Recorder model: hunts for the sync word in the stream, keeps the setup
 block and the last whole frame, and flags redundant counts that differ.
 Assumes one clock and a frame layout given by parameters.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tfm_map.svh"
module tfm_recorder_model
   import tfm_pkg::*;
#(
   parameter int FRAME_BITS = 480,
   parameter int SCNT_OFF = 152,
   parameter int PCNT_OFF = 328
) (
   input wire logic i_clk,
   input wire tfm_stream_t i_tx,
   output logic [31:0] o_setup,
   output logic [FRAME_BITS-1:0] o_frame,
   output logic [15:0] o_frame_cnt,
   output logic o_cnt_err
);
   logic [FRAME_BITS-1:0] shift_q;
   logic [FRAME_BITS-1:0] nxt;
   int pos_q;
   int setup_n_q;

   // Start empty so an idle recorder shows nothing
   initial begin
      shift_q = '0;
      pos_q = 0;
      setup_n_q = 0;
      o_setup = '0;
      o_frame = '0;
      o_frame_cnt = '0;
      o_cnt_err = 1'b0;
   end

   assign nxt = {shift_q[FRAME_BITS-2:0], i_tx.bit_out};

   // Layout offsets stand in for the stored scanlist
   // A sync match restarts the frame whatever came before
   always @(posedge i_clk) begin
      if (i_tx.bit_valid === 1'b1) begin
         shift_q <= nxt;
         if (setup_n_q < 32) begin
            o_setup <= nxt[31:0];
            setup_n_q <= setup_n_q + 1;
         end
         if (nxt[31:0] === `TFM_SYNC_WORD) begin
            pos_q <= 32;
         end else if (pos_q == FRAME_BITS - 1) begin
            pos_q <= 0;
            o_frame <= nxt;
            o_frame_cnt <= o_frame_cnt + 16'h0001;
            // Neither copy is trusted when they differ
            if (nxt[FRAME_BITS-1-SCNT_OFF -: 16] !== nxt[FRAME_BITS-17-SCNT_OFF -: 16] ||
                nxt[FRAME_BITS-1-PCNT_OFF -: 16] !== nxt[FRAME_BITS-17-PCNT_OFF -: 16]) begin
               o_cnt_err <= 1'b1;
            end
         end else if (pos_q > 0) begin
            pos_q <= pos_q + 1;
         end
      end
   end
endmodule : tfm_recorder_model
`default_nettype wire

// ===== sim/tfm_framer_tb_top.sv
/*
 Testbench of the frame multiplexer: drives time, serial, parallel and
 analog inputs and checks whole frames caught by the recorder model.
 Assumes default framer sizes: one serial, parallel and analog channel.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tfm_map.svh"
module tfm_framer_tb_top;
   import tfm_pkg::*;
   localparam int SER_N = 8 + (16 + 99) / 100;
   localparam int PAR_N = 8 + (16 + 99) / 100;
   localparam int ANA_N = 4;
   localparam int O_TC = 32;
   localparam int O_FILL = O_TC + 64;
   localparam int O_SCNT = O_FILL + 7 * 8;
   localparam int O_SDAT = O_SCNT + 32;
   localparam int O_PCNT = O_SDAT + SER_N * 16;
   localparam int O_PDAT = O_PCNT + 32;
   localparam int O_ANA = O_PDAT + PAR_N * 8;
   localparam int FB = O_ANA + ANA_N * 12;
   localparam tfm_time_t T1 = {10'h16d, 6'h17, 7'h3b, 7'h3b, 12'h3e7, 14'h2705, 2'b10};
   localparam tfm_time_t T2 = {10'h0a5, 6'h05, 7'h2a, 7'h15, 12'h555, 14'h1555, 2'b01};

   logic i_clk;
   logic i_rst_b;
   tfm_time_t i_time;
   logic i_ser_bit;
   logic i_ser_valid;
   logic [7:0] i_par_word;
   logic i_par_valid;
   logic [11:0] i_ana_sample;
   tfm_stream_t o_tx;
   logic o_ana_strobe;
   logic [31:0] o_setup;
   logic [FB-1:0] o_frame;
   logic [15:0] o_frame_cnt;
   logic o_cnt_err;
   int fail_count = 0;
   int comparisons = 0;
   int fidx = 0;
   int ns = 0;
   int gap = 0;
   int sgap = 0;
   int k = 0;
   int exp_ser;
   int exp_par;
   tfm_time_t t_exp;
   logic [11:0] prev_ana;
   logic [11:0] ana_s [0:15][0:3];

   tfm_framer #(.FILL_BYTES(7), .SER_NOM_WORDS(8), .PAR_NOM_WORDS(8),
      .ANA_W(12), .ANA_NOM(4), .SETUP_IMG({16'habcd, 16'h1234})) u_tfm_framer (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_time(i_time), .i_ser_bit(i_ser_bit),
      .i_ser_valid(i_ser_valid), .i_par_word(i_par_word), .i_par_valid(i_par_valid),
      .i_ana_sample(i_ana_sample), .o_tx(o_tx), .o_ana_strobe(o_ana_strobe));

   tfm_recorder_model #(.FRAME_BITS(FB), .SCNT_OFF(O_SCNT), .PCNT_OFF(O_PCNT))
      u_tfm_recorder_model (.i_clk(i_clk), .i_tx(o_tx), .o_setup(o_setup),
      .o_frame(o_frame), .o_frame_cnt(o_frame_cnt), .o_cnt_err(o_cnt_err));

   // Clock and a sample source that changes every cycle
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      i_ana_sample <= i_ana_sample + 12'h0b3;
   end

   // Uses pre-edge values, so it never races the design or the tasks
   always @(posedge i_clk) begin
      if (o_tx.frame_start === 1'b1) begin
         if (fidx > 0) begin
            check_val(gap, FB);
            check_val(ns, ANA_N);
         end
         fidx++;
         ns = 0;
         gap = 0;
      end
      if (o_ana_strobe === 1'b1) begin
         if (ns > 0 && fidx > 0) check_val(sgap, FB / ANA_N);
         if (ns < ANA_N) ana_s[fidx][ns] = prev_ana;
         ns++;
         sgap = 0;
      end
      gap++;
      sgap++;
      prev_ana = i_ana_sample;
   end

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_val

   function automatic logic [31:0] fld(input int off, input int w);
      logic [63:0] m;
      m = (64'h1 << w) - 64'h1;
      fld = 32'(64'(o_frame >> (FB - off - w)) & m);
   endfunction : fld

   function automatic logic pb(input int i);
      logic [31:0] v;
      v = i;
      pb = v[0] ^ v[2] ^ v[5];
   endfunction : pb

   // A start already showing is taken, so back-to-back frames are not skipped
   task automatic wait_start;
      int n;
      n = 0;
      while (o_tx.frame_start !== 1'b1 && n < 2 * FB) begin
         @(negedge i_clk);
         n++;
      end
      check_val(o_tx, 3'b111);
   endtask : wait_start

   // Feeds one frame of input, then checks the frame that carries the last one
   task automatic run_frame(input int nser, input int npar, input tfm_time_t tnext);
      logic [15:0] tgt;
      logic [31:0] ev;
      int n;
      int c;
      int w;
      wait_start();
      k++;
      tgt = o_frame_cnt + 16'h0001;
      @(posedge i_clk);
      i_time <= tnext;
      for (c = 0; c < nser || c < npar; c++) begin
         i_ser_valid <= (c < nser);
         i_ser_bit <= pb(c);
         i_par_valid <= (c < npar);
         i_par_word <= 8'h40 + 8'(c);
         @(posedge i_clk);
      end
      i_ser_valid <= 1'b0;
      i_par_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (o_frame_cnt !== tgt && n < 2 * FB);
      check_val(o_frame_cnt, tgt);
      check_val(fld(0, 32), `TFM_SYNC_WORD);
      ev = {8'h00, t_exp.day, 1'b0, t_exp.hour, t_exp.minute};
      check_val(fld(O_TC, 24), ev);
      ev = {9'h000, t_exp.second, t_exp.time_sync_error_flag, t_exp.time_input_absent_flag,
         2'b00, t_exp.millisecond_field};
      check_val(fld(O_TC + 24, 24), ev);
      check_val(fld(O_TC + 48, 16), {18'h00000, t_exp.sub_ms_hundred_ns});
      for (w = 0; w < 7; w++) check_val(fld(O_FILL + 8 * w, 8), 8'hff);
      check_val(fld(O_SCNT, 16), exp_ser);
      check_val(fld(O_SCNT + 16, 16), exp_ser);
      if (exp_ser > 0) check_val(fld(O_SDAT, 1), pb(0));
      for (w = 0; w < SER_N; w++) begin
         ev = 32'h0000ffff;
         for (c = 0; c < 16 && w * 16 < exp_ser; c++) ev[15-c] = (w * 16 + c < exp_ser) & pb(w * 16 + c);
         check_val(fld(O_SDAT + 16 * w, 16), ev);
      end
      check_val(fld(O_PCNT, 16), exp_par);
      check_val(fld(O_PCNT + 16, 16), exp_par);
      for (w = 0; w < PAR_N; w++) begin
         ev = (w < exp_par) ? 32'h40 + w : 32'hff;
         check_val(fld(O_PDAT + 8 * w, 8), ev);
      end
      for (w = 0; w < ANA_N && k > 1; w++) begin
         check_val(fld(O_ANA + 12 * w, 12), ana_s[k-1][w]);
      end
   endtask : run_frame

   task automatic t_setup;
      repeat (2) @(posedge i_clk);
      check_val({o_tx, o_ana_strobe}, 4'h0);
      i_rst_b <= 1'b1;
      wait_start();
      check_val(o_setup, 32'h1234abcd);
      $display("Test setup block done");
   endtask : t_setup

   task automatic t_first_frame;
      t_exp = T1;
      exp_ser = 0;
      exp_par = 0;
      run_frame(20, 3, T2);
      $display("Test first frame and time latch done");
   endtask : t_first_frame

   task automatic t_partial;
      t_exp = T2;
      exp_ser = 20;
      exp_par = 3;
      run_frame(150, 12, T1);
      $display("Test partial channels done");
   endtask : t_partial

   task automatic t_overflow;
      t_exp = T1;
      exp_ser = SER_N * 16;
      exp_par = PAR_N;
      run_frame(0, 0, T1);
      check_val(o_cnt_err, 1'b0);
      $display("Test full channels done");
   endtask : t_overflow

   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   // Main sequence
   initial begin
      i_rst_b = 1'b0;
      i_time = T1;
      i_ser_bit = 1'b0;
      i_ser_valid = 1'b0;
      i_par_word = 8'h00;
      i_par_valid = 1'b0;
      i_ana_sample = 12'h000;
      #1;
      t_setup();
      t_first_frame();
      t_partial();
      t_overflow();
      conclude();
   end

   // Setup and three frames need about 1500 cycles; over ten times that means a hang
   initial begin
      #200000;
      fail_count++;
      conclude();
   end
endmodule : tfm_framer_tb_top
`default_nettype wire
